// >>> src/fcm_flash_config_master.sv
// Configuration master that streams an image out of an external flash.
// Assumes inputs synchronous to clk_i and pads resolved outside from the oe outputs.
//
// Functional notes
// R1 - While configuring, flash_select_n is driven low to enable the serial flash.
// R2 - Read command and address bits leave serially on command_out, shifted by config_clock.
// R3 - The flash returns image bits serially on config_data_in.
// R4 - At completion config_clock, flash_select_n and command_out are released high-impedance, read high.
// R5 - From the internal oscillator config_clock runs between 20 MHz and 40 MHz; here 25 MHz, and stalls on a full word buffer stretch it below 20 MHz.
// R6 - An option selects user_clock_input instead of the oscillator as config_clock source.
// R7 - In active_parallel_mode config_clock always comes from the internal oscillator.
// R8 - In active_parallel_mode one 16-bit word is taken from the flash per config_clock cycle.
// R9 - Reading continues after one command until the whole image is received, then the flash is released.
`timescale 1ns/1ns
module fcm_flash_config_master
    import fcm_pkg::*;
#(
    parameter int               IMAGE_WORDS = IMAGE_WORDS_DEF,
    parameter logic [CMD_W-1:0] READ_CMD    = 8'h03,
    parameter logic [ADDR_W-1:0] START_ADDR = 24'h00_0000
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Control
    input  wire logic              start_i,
    input  wire logic              parallel_mode_i,
    input  wire logic              use_user_clock_i,
    output logic                   busy_o,
    output logic                   done_o,
    // Flash pins
    input  wire logic              user_clock_input_i,
    input  wire logic              config_data_in_i,
    input  wire logic [WORD_W-1:0] parallel_config_data_i,
    output logic                   config_clock_o,
    output logic                   config_clock_oe_o,
    output logic                   flash_select_n_o,
    output logic                   flash_select_n_oe_o,
    output logic                   command_out_o,
    output logic                   command_out_oe_o,
    // Image word stream
    output logic                   word_valid_o,
    output logic [WORD_W-1:0]      word_data_o,
    input  wire logic              word_ready_i
);
    localparam int CNT_W = $clog2(IMAGE_WORDS + 1);
    localparam logic [CNT_W-1:0] LAST_WORD = CNT_W'(IMAGE_WORDS - 1);

    typedef struct packed {
        fcm_state_e          st;
        logic [3:0]          div;
        logic                osc;
        logic                ucl;
        logic                src_q;
        logic                clk_lvl;
        logic                drv;
        logic                sel_n;
        logic                cmd_bit;
        logic [CMD_BITS-1:0] cmd_sr;
        logic [5:0]          bit_cnt;
        logic [WORD_W-1:0]   shin;
        logic [3:0]          nbit;
        logic [CNT_W-1:0]    word_cnt;
        logic                push;
        logic [WORD_W-1:0]   push_data;
        logic                par;
        logic                user_src;
        logic                busy;
        logic                done;
    } fcm_master_s;

    fcm_master_s r;
    fcm_master_s next_r;
    logic        src;
    logic        rise;
    logic        fall;
    logic        stall;
    logic        buf_ready;
    logic [WORD_W-1:0] word;

    always_comb begin
        next_r      = r;
        next_r.push = 1'b0;
        next_r.ucl  = user_clock_input_i;
        word        = '0;
        // Free-running oscillator, kept alive so restarts need no warm-up
        if (r.div == CFG_HALF_CYC - 4'h1) begin // R5
            next_r.div = 4'h0;
            next_r.osc = ~r.osc;
        end else begin
            next_r.div = r.div + 4'h1;
        end
        src          = r.user_src ? r.ucl : r.osc; // R6 R7
        next_r.src_q = src;
        rise         = src && !r.src_q;
        fall         = !src && r.src_q;
        // Pending push is counted too, so the buffer can never be overrun
        stall        = !buf_ready || r.push;

        if (start_i && (r.st == FCM_IDLE || r.st == FCM_DONE)) begin
            next_r.busy     = 1'b1;
            next_r.done     = 1'b0;
            next_r.sel_n    = 1'b0; // R1
            next_r.drv      = 1'b1;
            next_r.clk_lvl  = 1'b0;
            next_r.par      = parallel_mode_i;
            next_r.user_src = use_user_clock_i && !parallel_mode_i; // R6 R7
            next_r.cmd_sr   = {READ_CMD, START_ADDR};
            next_r.cmd_bit  = READ_CMD[CMD_W-1]; // R2
            next_r.bit_cnt  = 6'h00;
            next_r.nbit     = 4'h0;
            next_r.word_cnt = '0;
            next_r.st       = parallel_mode_i ? FCM_DATA : FCM_CMD;
        end else begin
            case (r.st)
                FCM_CMD: begin
                    if (rise) begin
                        next_r.clk_lvl = 1'b1;
                        next_r.bit_cnt = r.bit_cnt + 6'h01;
                    end else if (fall && r.clk_lvl) begin
                        // A fall before the first rise would shift out a header bit unseen
                        // Bits change on the falling edge, flash samples on the rising one
                        next_r.clk_lvl = 1'b0;
                        next_r.cmd_sr  = {r.cmd_sr[CMD_BITS-2:0], 1'b0}; // R2
                        next_r.cmd_bit = r.cmd_sr[CMD_BITS-2];
                        if (r.bit_cnt == CMD_BITS_V) begin
                            next_r.st = FCM_DATA;
                        end
                    end
                end
                FCM_DATA: begin
                    if (fall) begin
                        next_r.clk_lvl = 1'b0;
                    end else if (rise && !stall) begin
                        // A stalled rise simply stretches config_clock low
                        next_r.clk_lvl = 1'b1;
                        word           = {r.shin[WORD_W-2:0], config_data_in_i}; // R3
                        if (r.par) begin
                            next_r.push = 1'b1;
                            next_r.push_data = parallel_config_data_i; // R8
                        end else begin
                            next_r.shin = word;
                            next_r.nbit = r.nbit + 4'h1;
                            next_r.push = (r.nbit == 4'(WORD_W - 1));
                            next_r.push_data = word;
                        end
                        if (next_r.push) begin
                            next_r.word_cnt = r.word_cnt + CNT_W'(1);
                            if (r.word_cnt == LAST_WORD) begin // R9
                                next_r.st      = FCM_DONE;
                                next_r.drv     = 1'b0; // R4
                                next_r.sel_n   = 1'b1;
                                next_r.clk_lvl = 1'b1;
                                next_r.cmd_bit = 1'b1;
                                next_r.busy    = 1'b0;
                                next_r.done    = 1'b1;
                            end
                        end
                    end
                end
                FCM_IDLE, FCM_DONE: begin
                    next_r.st = r.st;
                end
                default: begin
                    next_r.st = FCM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r         <= '0;
            r.st      <= FCM_IDLE;
            r.sel_n   <= 1'b1;
            r.clk_lvl <= 1'b1;
            r.cmd_bit <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    fcm_pair_buf #(
        .W     (WORD_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (r.push),
        .in_data_i   (r.push_data),
        .in_ready_o  (buf_ready),
        .out_valid_o (word_valid_o),
        .out_data_o  (word_data_o),
        .out_ready_i (word_ready_i)
    );

    assign busy_o              = r.busy;
    assign done_o              = r.done;
    assign config_clock_o      = r.clk_lvl;
    assign config_clock_oe_o   = r.drv;
    assign flash_select_n_o    = r.sel_n;
    assign flash_select_n_oe_o = r.drv;
    assign command_out_o       = r.cmd_bit;
    assign command_out_oe_o    = r.drv;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    select_low_a: assert property (busy_o |-> !flash_select_n_o && flash_select_n_oe_o) // R1
        else $error("flash select not low while busy");
    cmd_shift_a: assert property ((r.st == FCM_CMD) && $changed(command_out_o) |-> !config_clock_o) // R2
        else $error("command bit changed while config clock high");
    release_pins_a: assert property (done_o |-> !config_clock_oe_o && !flash_select_n_oe_o // R4
                                     && !command_out_oe_o && config_clock_o && flash_select_n_o && command_out_o)
        else $error("flash pins not released after completion");
    osc_high_time_a: assert property ($rose(config_clock_o) && busy_o && !r.user_src // R5
                                      |-> config_clock_o [*2] ##1 (!config_clock_o || done_o))
        else $error("internal config clock high phase wrong");
    user_clock_a: assert property ($rose(config_clock_o) && r.user_src |-> $past(r.ucl) && !$past(r.src_q)) // R6
        else $error("config clock not following user clock");
    par_osc_a: assert property ($rose(config_clock_o) && busy_o && r.par // R7
                                |-> !r.user_src ##0 config_clock_o [*2] ##1 (!config_clock_o || done_o))
        else $error("parallel mode not on internal oscillator");
    par_word_a: assert property ($rose(config_clock_o) && r.par && ($past(r.st) == FCM_DATA) // R8
                                 |-> r.push && r.push_data == $past(parallel_config_data_i))
        else $error("parallel word not taken on config clock rise");
    image_len_a: assert property ($rose(done_o) |-> r.word_cnt == CNT_W'(IMAGE_WORDS) && $past(busy_o)) // R9
        else $error("completion before full image");

    serial_done_c: cover property ($rose(done_o) && !r.par);
    parallel_done_c: cover property ($rose(done_o) && r.par);
    stall_c: cover property ((r.st == FCM_DATA) && rise && stall);

endmodule : fcm_flash_config_master

// >>> src/fcm_pair_buf.sv
// Small valid/ready buffer between the flash reader and the word consumer.
// Assumes one clock, synchronous active-low reset; output stage is entry 0.
`timescale 1ns/1ns
module fcm_pair_buf
    import fcm_pkg::*;
#(
    parameter int W     = WORD_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Fill side
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    // Drain side
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [CW-1:0]           cnt;
        logic                    vld;
    } fcm_buf_s;

    fcm_buf_s r;
    fcm_buf_s next_r;
    logic     pop;
    logic     push;
    logic [CW-1:0] idx;

    always_comb begin
        next_r = r;
        pop    = out_ready_i && r.vld;
        push   = in_valid_i && (r.cnt != CW'(DEPTH));
        idx    = r.cnt - CW'(pop);
        if (pop) begin
            // Shift so the head always sits in a flip-flop at index 0
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_r.mem[i] = r.mem[i + 1];
            end
        end
        if (push) begin
            next_r.mem[idx] = in_data_i;
        end
        next_r.cnt = r.cnt + CW'(push) - CW'(pop);
        next_r.vld = (next_r.cnt != '0);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign in_ready_o  = (r.cnt != CW'(DEPTH));
    assign out_valid_o = r.vld;
    assign out_data_o  = r.mem[0];

endmodule : fcm_pair_buf

// >>> src/fcm_pkg.sv
// Shared constants and types for the flash configuration master.
// Assumes a single 100 MHz system clock; all pin inputs are synchronous to it.
package fcm_pkg;

    // System clock period
    localparam int CLK_PERIOD_NS        = 10;
    // Internal oscillator config_clock limits: 40 MHz max, 20 MHz min
    localparam int CFG_CLK_MIN_PER_NS   = 25;
    localparam int CFG_CLK_MAX_PER_NS   = 50;
    // Half period in system cycles; rounded up so the 40 MHz ceiling holds
    localparam int CFG_HALF_CYC_INT     = (CFG_CLK_MIN_PER_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
    localparam logic [3:0] CFG_HALF_CYC = 4'(CFG_HALF_CYC_INT);

    // Serial read header: 8-bit command then 24-bit address
    localparam int CMD_W                = 8;
    localparam int ADDR_W               = 24;
    localparam int CMD_BITS             = CMD_W + ADDR_W;
    localparam logic [5:0] CMD_BITS_V   = 6'(CMD_BITS);

    // Configuration word and default image size
    localparam int WORD_W               = 16;
    localparam int IMAGE_BITS           = 9_600_000;
    localparam int IMAGE_WORDS_DEF      = IMAGE_BITS / WORD_W;

    // Word buffer depth
    localparam int BUF_DEPTH            = 2;

    typedef enum logic [1:0] {
        FCM_IDLE,
        FCM_CMD,
        FCM_DATA,
        FCM_DONE
    } fcm_state_e;

endpackage : fcm_pkg

// >>> tb/fcm_flash_model.sv
// Behavioural configuration flash: serial read header in, image bits or words out.
// Assumes pad levels already resolved with pull-ups; the bench loads mem before each load.
`timescale 1ns/1ns
module fcm_flash_model
    import fcm_pkg::*;
(
    // Mode of the attached flash
    input  wire logic         par_i,
    // Pads from the loader
    input  wire logic         sel_n_i,
    input  wire logic         sclk_i,
    input  wire logic         cmd_i,
    // Data towards the loader
    output logic              data_o,
    output logic [WORD_W-1:0] pdata_o
);
    logic [WORD_W-1:0] mem [0:7];
    logic [31:0]       header;
    int                hcnt;
    int                bitn;
    int                widx;
    logic              rose;

    initial begin
        data_o  = 1'b1;
        pdata_o = 16'h5a5a;
        rose    = 1'b0;
    end
    always @(negedge sel_n_i) begin
        hcnt    = 0;
        bitn    = 0;
        widx    = 0;
        pdata_o = mem[0];
    end
    // Released lines: serial data pulled up, parallel bus shows garbage
    always @(posedge sel_n_i) begin
        data_o  = 1'b1;
        pdata_o = ~pdata_o;
        rose    = 1'b0;
    end
    always @(posedge sclk_i) begin
        rose = !sel_n_i;
        if (!sel_n_i && !par_i && hcnt < CMD_BITS) begin
            header = {header[30:0], cmd_i};
            hcnt++;
        end
    end
    // New data only after a rise, so the start-up fall of the clock is ignored
    always @(negedge sclk_i) begin
        if (!sel_n_i && rose) begin
            if (par_i) begin
                widx++;
                pdata_o = mem[widx[2:0]];
            end else if (hcnt == CMD_BITS) begin
                data_o = mem[(bitn / 16) % 8][15 - bitn % 16];
                bitn++;
            end
        end
    end
endmodule : fcm_flash_model

// >>> tb/tb.sv
// Self-checking bench for the flash configuration master with a flash model.
// Assumes a 100 MHz clock, a shortened image of four words and a random word consumer.
`timescale 1ns/1ns
module tb;
    import fcm_pkg::*;
    localparam int NW = 4;
    logic              clk_i = 0, rst_n_i = 0, start_i = 0, par = 0, useu = 0, uclk = 0, uclk_en = 0, ready = 0;
    logic              data_w, cclk, cclk_oe, sel_n, sel_oe, cmd, cmd_oe, busy, done, wvalid;
    logic              cclk_pad, sel_pad, cmd_pad;
    logic [WORD_W-1:0] pdata_w, wdata;
    logic [WORD_W-1:0] expq [$];
    int                bad_count = 0, cmp_count = 0, cycles = 0, stall_cnt = 0;
    int unsigned       seed = 37280;
    realtime           last_rise, min_per;

    assign cclk_pad = cclk_oe ? cclk : 1'b1;
    assign sel_pad  = sel_oe ? sel_n : 1'b1;
    assign cmd_pad  = cmd_oe ? cmd : 1'b1;

    fcm_flash_config_master #(.IMAGE_WORDS(NW)) i_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i), .parallel_mode_i(par),
        .use_user_clock_i(useu), .busy_o(busy), .done_o(done), .user_clock_input_i(uclk),
        .config_data_in_i(data_w), .parallel_config_data_i(pdata_w), .config_clock_o(cclk),
        .config_clock_oe_o(cclk_oe), .flash_select_n_o(sel_n), .flash_select_n_oe_o(sel_oe),
        .command_out_o(cmd), .command_out_oe_o(cmd_oe), .word_valid_o(wvalid),
        .word_data_o(wdata), .word_ready_i(ready));

    fcm_flash_model i_flash (.par_i(par), .sel_n_i(sel_pad), .sclk_i(cclk_pad), .cmd_i(cmd_pad),
        .data_o(data_w), .pdata_o(pdata_w));

    always #5 clk_i = ~clk_i;
    // Slow user clock, stopped outside user-clock loads
    always #40 uclk = uclk_en ? ~uclk : 1'b0;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            close_out();
        end else if (wvalid && ready) begin
            chk(wdata, expq.pop_front());
        end
    end
    // Consumer stalls when asked, otherwise takes words at random
    always @(negedge clk_i) begin
        ready <= (stall_cnt > 0) ? 1'b0 : 1'(rnd() & 32'h0000_0001);
        if (stall_cnt > 0)
            stall_cnt--;
    end
    // Stretched phases only lengthen the period, so only the minimum is checked
    always @(posedge cclk_pad) begin
        if (busy && last_rise > 0)
            chk(($realtime - last_rise) >= min_per, 1);
        last_rise = $realtime;
    end

    task automatic load(input logic p, input logic u, input int stall);
        int n;
        for (n = 0; n < NW; n++) begin
            i_flash.mem[n] = 16'(rnd());
            expq.push_back(i_flash.mem[n]);
        end
        par       = p;
        useu      = u;
        min_per   = (u && !p) ? 70 : CFG_CLK_MIN_PER_NS;
        last_rise = 0;
        stall_cnt = stall;
        start_i   = 1'b1;
        @(negedge clk_i);
        start_i   = 1'b0;
        uclk_en   = u && !p;
        @(negedge clk_i);
        chk({sel_n, sel_oe, cclk_oe, busy}, 32'h0000_0007);
        repeat (5) @(negedge clk_i);
        start_i = 1'b1;
        @(negedge clk_i);
        start_i = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge clk_i);
            n++;
        end
        chk({cclk_oe, sel_oe, cmd_oe, cclk, sel_n, cmd, busy, done}, 32'h0000_001d);
        repeat (20) @(negedge clk_i);
        chk(expq.size(), 0);
        if (!p)
            chk(i_flash.header, {8'h03, 24'h00_0000});
        uclk_en = 1'b0;
    endtask : load

    initial begin
        repeat (16) @(negedge clk_i);
        chk({cclk_oe, sel_oe, cmd_oe, cclk, sel_n, cmd, busy, done, wvalid}, 32'h0000_0038);
        rst_n_i = 1'b1;
        load(1'b0, 1'b0, 0);
        load(1'b0, 1'b0, 200);
        load(1'b1, 1'b0, 0);
        load(1'b1, 1'b1, 30);
        load(1'b0, 1'b1, 0);
        close_out();
    end
endmodule : tb
